// >>> kms_consts.svh
`ifndef KMS_CONSTS_SVH
`define KMS_CONSTS_SVH

// register addresses
`define KMS_A_FIFO      8'h00
`define KMS_A_CFG       8'h01
`define KMS_A_DEB       8'h02
`define KMS_A_IRQ       8'h03
`define KMS_A_PORTS     8'h04
`define KMS_A_REP       8'h05
`define KMS_A_SLEEP     8'h06

// power-up values, empty and repeat codes
`define KMS_RST_CFG     8'h0a
`define KMS_RST_DEB     8'hff
`define KMS_RST_IRQ     8'h00
`define KMS_RST_PORTS   8'hfe
`define KMS_RST_REP     8'h00
`define KMS_RST_SLEEP   8'h07
`define KMS_EMPTY       8'h3f
`define KMS_REPEAT      7'h7e

// field positions
`define KMS_CFG_RUN     7
`define KMS_CFG_HOLD    5
`define KMS_CFG_REL     3
`define KMS_CFG_WAKE    1
`define KMS_PORT_IRQ    1
`define KMS_REP_EN      7

// timing
`define KMS_CLK_HZ      200000000
`define KMS_TICK_HZ     64000
`define KMS_TICK_CYC    (`KMS_CLK_HZ / `KMS_TICK_HZ)
`define KMS_TICK_PER_MS (`KMS_TICK_HZ / 1000)
`define KMS_DEB_MIN_MS  9
`define KMS_WAKE_MS     2
`define KMS_WAKE_TICKS  (`KMS_WAKE_MS * `KMS_TICK_PER_MS)
`define KMS_SLEEP_SHIFT 12
`define KMS_DLY_STEP    8
`define KMS_RATE_STEP   4

`endif

// >>> kms_pkg.sv
package kms_pkg;

  typedef struct packed {
    logic       rel;
    logic [5:0] key;
  } kms_entry_type;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] deb;
    logic [7:0] irq;
    logic [7:0] ports;
    logic [7:0] rep;
    logic [7:0] sleep;
  } kms_regs_type;

  typedef enum logic [2:0] {
    KMS_SLEEP = 3'b001,
    KMS_WAKE  = 3'b010,
    KMS_RUN   = 3'b100
  } kms_state_type;

endpackage

// >>> kms_key_scanner.sv
`timescale 1ns/100ps
`include "kms_consts.svh"

// Notes on behaviour
// - entry key number is column*8 plus row
// - bit 7 flags more data, not keys 62/63
// - bit 6 marks press or release
// - queue read clears interrupt per mode bit
// - config bit 7 sets and shows sleep
// - debounce 9 to 40 ms, 1 ms steps
// - fixed codes pick spare columns as outputs
// - zero interrupt setup makes pin an output
// - time interrupt after 1-31 debounce cycles
// - count interrupt at 2 to 14 events
// - whichever interrupt condition first wins
// - pin levels apply only to output pins
// - autorepeat queues 0x7E, not the key
// - first repeat after 8-128 debounce cycles
// - repeat interval 4-32 debounce cycles
// - one repeat code per interval until event
// - release with keys held restarts repeat
// - autosleep after idle time, queue kept
// - wake by write or keypress, bit readable
// - wake within 2 ms, waking key kept
// - config bit 1 clear stops keypress wake
// - timing from 64 kHz tick, debounce cycles
// - power-up values, starts asleep

module kms_fifo
#(
  parameter  int WIDTH = 7,
  parameter  int DEPTH = 4,
  localparam int CW    = $clog2(DEPTH + 1),
  localparam int AW    = $clog2(DEPTH)
)
(
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [CW-1:0]         count
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [CW-1:0]    cnt_q;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rp_q];
  assign count     = cnt_q;

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wp_q] <= in_data;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= nxt(wp_q);
      if (pop)
        rp_q <= nxt(rp_q);
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end
endmodule

module kms_key_scanner
#(
  parameter  int DEPTH    = 4,
  parameter  int TICK_CYC = `KMS_TICK_CYC,
  localparam int CW       = $clog2(DEPTH + 1)
)
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // register access port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  // switch matrix, bit column*8+row, 1 = closed
  input  wire logic [63:0] scan_row,
  // open-drain pins
  output logic [5:0]       spare_column_outputs_o,
  output logic [5:0]       spare_column_outputs_oe,
  output logic             key_event_irq_n_o,
  output logic             key_event_irq_n_oe
);
  localparam int WAKE_TICKS = `KMS_WAKE_TICKS;

  function automatic logic [11:0] ms_ticks(input logic [5:0] ms);
    ms_ticks = 12'(ms) * 12'(`KMS_TICK_PER_MS);
  endfunction

  // code n hands the top n columns over; 6 and 7 give all six
  function automatic logic [5:0] gpo_cols(input logic [2:0] code);
    gpo_cols = ~(6'h3f >> code);
  endfunction

  function automatic logic [63:0] scan_mask(input logic [5:0] gpo);
    scan_mask = '1;
    for (int c = 2; c < 8; c++)
      if (gpo[c-2])
        scan_mask[c*8 +: 8] = 8'h00;
  endfunction

  function automatic logic [5:0] first_key(input logic [63:0] m);
    first_key = 6'h00;
    for (int i = 63; i >= 0; i--)
      if (m[i])
        first_key = 6'(i);
  endfunction

  kms_pkg::kms_regs_type  regs_q;
  kms_pkg::kms_state_type state_q;
  kms_pkg::kms_state_type state_d;
  kms_pkg::kms_entry_type fin;
  kms_pkg::kms_entry_type fout;
  logic [7:0]             rdata_q;
  logic [11:0]            div_q;
  logic [11:0]            dcnt_q;
  logic [11:0]            wcnt_q;
  logic [63:0]            samp_q;
  logic [63:0]            agree_q;
  logic [63:0]            stab_q;
  logic [4:0]             tcnt_q;
  logic                   tarm_q;
  logic [7:0]             rcnt_q;
  logic                   rfirst_q;
  logic                   rdue_q;
  logic [19:0]            idle_q;
  logic                   irq_q;
  logic [5:0]             col_oe_q;
  logic                   irq_oe_q;
  logic [CW-1:0]          fcnt;
  logic                   fvalid;
  logic                   fifo_rdy;

  // tick and debounce cycle
  wire        running  = (state_q == kms_pkg::KMS_RUN);
  wire        waking   = (state_q == kms_pkg::KMS_WAKE);
  wire        sleeping = (state_q == kms_pkg::KMS_SLEEP);
  wire        tick     = (div_q == 12'(TICK_CYC - 1));
  wire [11:0] deb_len  =
    ms_ticks(6'(regs_q.deb[4:0]) + 6'(`KMS_DEB_MIN_MS));
  wire        db       = running && tick && (dcnt_q == deb_len - 12'h001);

  // key events
  wire [5:0]  gpo      = gpo_cols(regs_q.deb[7:5]);
  wire [63:0] keys     = scan_row & scan_mask(gpo);
  wire [63:0] pend     = agree_q & (samp_q ^ stab_q);
  wire [5:0]  pk       = first_key(pend);
  wire        pk_rel   = stab_q[pk];
  wire        key_ev   = running && (|pend);
  wire        key_push = key_ev && (!pk_rel || regs_q.cfg[`KMS_CFG_REL]);
  wire        take_key = key_ev && (fifo_rdy || !key_push);
  wire        rep_push = rdue_q && !key_ev;
  wire        rep_take = rep_push && fifo_rdy;
  wire        pushed   = (key_push || rep_push) && fifo_rdy;
  wire        any_held = |stab_q;

  // queue read side
  wire        rd_fifo   = reg_rd && (reg_addr == `KMS_A_FIFO);
  wire        pop       = rd_fifo && fvalid;
  wire        hi_key    = (fout.key[5:1] == 5'h1f);
  wire        more      = !hi_key && (fcnt > CW'(1));
  wire [7:0]  fifo_byte = fvalid ? {more, fout} : `KMS_EMPTY;

  // interrupt conditions
  wire [4:0]  tsel   = regs_q.irq[4:0];
  wire [2:0]  fsel   = regs_q.irq[7:5];
  wire        t_hit  = tarm_q && db && (tsel != 5'h00)
                       && (tcnt_q + 5'h01 == tsel);
  wire        f_hit  = (fsel != 3'h0) && (5'(fcnt) >= {1'b0, fsel, 1'b0});
  wire        irq_gpo = (regs_q.irq == 8'h00);
  wire        irq_clr = regs_q.cfg[`KMS_CFG_HOLD] ? !fvalid : pop;

  // autorepeat limits in debounce cycles
  wire [7:0]  rep_lim = rfirst_q
    ? 8'(regs_q.rep[3:0] + 5'h01) * 8'(`KMS_DLY_STEP)
    : 8'(regs_q.rep[6:4] + 4'h1) * 8'(`KMS_RATE_STEP);
  wire        rep_on  = regs_q.rep[`KMS_REP_EN] && any_held && running;

  // sleep control
  wire        wr_cfg    = reg_wr && (reg_addr == `KMS_A_CFG);
  wire        wr_run    = wr_cfg && reg_wdata[`KMS_CFG_RUN];
  wire        wr_slp    = wr_cfg && !reg_wdata[`KMS_CFG_RUN];
  wire [19:0] sleep_len = {regs_q.sleep, 12'h000};
  wire        idle_out  = (regs_q.sleep != 8'h00) && tick
                          && (idle_q == sleep_len - 20'h00001);
  wire        wake_done = tick && (wcnt_q == 12'(WAKE_TICKS - 1));
  wire        key_wake  = regs_q.cfg[`KMS_CFG_WAKE] && (|keys);

  wire [7:0] rd_mux =
    (reg_addr == `KMS_A_FIFO)  ? fifo_byte :
    (reg_addr == `KMS_A_CFG)   ? {!sleeping, regs_q.cfg[6:0]} :
    (reg_addr == `KMS_A_DEB)   ? regs_q.deb :
    (reg_addr == `KMS_A_IRQ)   ? regs_q.irq :
    (reg_addr == `KMS_A_PORTS) ? regs_q.ports :
    (reg_addr == `KMS_A_REP)   ? regs_q.rep :
    (reg_addr == `KMS_A_SLEEP) ? regs_q.sleep : 8'h00;

  assign fin = rep_push ? kms_pkg::kms_entry_type'(`KMS_REPEAT)
                        : {pk_rel, pk};
  assign reg_rdata               = rdata_q;
  assign spare_column_outputs_o  = 6'h00;
  assign spare_column_outputs_oe = col_oe_q;
  assign key_event_irq_n_o       = 1'b0;
  assign key_event_irq_n_oe      = irq_oe_q;

  kms_fifo #(.WIDTH(7), .DEPTH(DEPTH)) u_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (key_push || rep_push),
    .in_ready  (fifo_rdy),
    .in_data   (fin),
    .out_valid (fvalid),
    .out_ready (pop),
    .out_data  (fout),
    .count     (fcnt)
  );

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      kms_pkg::KMS_SLEEP:
        if (wr_run)
          state_d = kms_pkg::KMS_RUN;
        else if (key_wake)
          state_d = kms_pkg::KMS_WAKE;
      kms_pkg::KMS_WAKE:
        if (wr_slp)
          state_d = kms_pkg::KMS_SLEEP;
        else if (wr_run || wake_done)
          state_d = kms_pkg::KMS_RUN;
      kms_pkg::KMS_RUN:
        if (wr_slp || idle_out)
          state_d = kms_pkg::KMS_SLEEP;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      regs_q  <= {`KMS_RST_CFG, `KMS_RST_DEB, `KMS_RST_IRQ,
                  `KMS_RST_PORTS, `KMS_RST_REP, `KMS_RST_SLEEP};
      state_q <= kms_pkg::KMS_SLEEP;
      rdata_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      if (reg_rd)
        rdata_q <= rd_mux;
      if (reg_wr)
        unique case (reg_addr)
          `KMS_A_CFG:   regs_q.cfg   <= reg_wdata;
          `KMS_A_DEB:   regs_q.deb   <= reg_wdata;
          `KMS_A_IRQ:   regs_q.irq   <= reg_wdata;
          `KMS_A_PORTS: regs_q.ports <= reg_wdata;
          `KMS_A_REP:   regs_q.rep   <= reg_wdata;
          `KMS_A_SLEEP: regs_q.sleep <= reg_wdata;
          default:      ;
        endcase
    end
  end

  // the tick runs even asleep so wake and idle timing stay exact
  always_ff @(posedge mclk)
  begin
    if (reset)
      div_q <= 12'h000;
    else
      div_q <= tick ? 12'h000 : div_q + 12'h001;
  end

  always_ff @(posedge mclk)
  begin
    if (reset || !running)
      dcnt_q <= 12'h000;
    else if (tick)
      dcnt_q <= db ? 12'h000 : dcnt_q + 12'h001;
  end

  always_ff @(posedge mclk)
  begin
    if (reset || !waking)
      wcnt_q <= 12'h000;
    else if (tick)
      wcnt_q <= wcnt_q + 12'h001;
  end

  // a key is accepted after agreeing over a whole debounce cycle
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      samp_q  <= '0;
      agree_q <= '0;
      stab_q  <= '0;
    end
    else
    begin
      if (db)
      begin
        samp_q  <= keys;
        agree_q <= ~(keys ^ samp_q);
      end
      if (take_key)
        stab_q[pk] <= samp_q[pk];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset || !running || any_held || (|keys))
      idle_q <= 20'h00000;
    else if (tick)
      idle_q <= idle_q + 20'h00001;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      tarm_q <= 1'b0;
      tcnt_q <= 5'h00;
    end
    else if (pushed)
    begin
      tarm_q <= 1'b1;
      tcnt_q <= 5'h00;
    end
    else if (t_hit)
      tarm_q <= 1'b0;
    else if (db && tarm_q)
      tcnt_q <= tcnt_q + 5'h01;
  end

  // set wins over clear
  always_ff @(posedge mclk)
  begin
    if (reset)
      irq_q <= 1'b0;
    else if (!irq_gpo && (t_hit || f_hit))
      irq_q <= 1'b1;
    else if (irq_clr || irq_gpo)
      irq_q <= 1'b0;
  end

  // one code per interval however many keys are held
  always_ff @(posedge mclk)
  begin
    if (reset || take_key || !rep_on)
    begin
      rcnt_q   <= 8'h00;
      rfirst_q <= 1'b1;
      rdue_q   <= 1'b0;
    end
    else
    begin
      if (rep_take)
        rdue_q <= 1'b0;
      if (db && (rcnt_q + 8'h01 == rep_lim))
      begin
        rcnt_q   <= 8'h00;
        rfirst_q <= 1'b0;
        rdue_q   <= 1'b1;
      end
      else if (db)
        rcnt_q <= rcnt_q + 8'h01;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      col_oe_q <= 6'h00;
      irq_oe_q <= 1'b0;
    end
    else
    begin
      col_oe_q <= gpo & ~regs_q.ports[7:2];
      irq_oe_q <= irq_gpo ? !regs_q.ports[`KMS_PORT_IRQ] : irq_q;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_empty_read: assert property (
    rd_fifo && !fvalid && !pushed |=> reg_rdata == `KMS_EMPTY && !fvalid)
    else $error("empty read gave wrong value");
  chk_more_set: assert property (
    rd_fifo && fvalid && !hi_key && fcnt > CW'(1) |=> reg_rdata[7])
    else $error("more flag missing");
  chk_more_hi: assert property (
    rd_fifo && fvalid && hi_key |=> !reg_rdata[7])
    else $error("more flag set for high key");
  chk_release_ev: assert property (
    key_push && fifo_rdy && pk_rel |=> !stab_q[$past(pk)])
    else $error("release not recorded");
  chk_irq_gpo: assert property (
    irq_gpo && !regs_q.ports[`KMS_PORT_IRQ] |=> key_event_irq_n_oe)
    else $error("interrupt pin not following port bit");
  chk_fifo_irq: assert property (
    !irq_gpo && f_hit |=> irq_q)
    else $error("count interrupt missed");
  chk_time_irq: assert property (
    !irq_gpo && t_hit |=> irq_q ##1 (irq_q || $past(irq_clr || irq_gpo)))
    else $error("time interrupt missed");
  chk_read_clear: assert property (
    !regs_q.cfg[`KMS_CFG_HOLD] && pop && !t_hit && !f_hit |=> !irq_q)
    else $error("read did not clear interrupt");
  chk_gpo_cols: assert property (
    regs_q.deb[7:5] == 3'h0 |=> spare_column_outputs_oe == 6'h00)
    else $error("column driven while scanned");
  chk_sleep_read: assert property (
    reg_rd && reg_addr == `KMS_A_CFG |=> reg_rdata[7] == !$past(sleeping))
    else $error("sleep bit wrong");
  chk_tick_gap: assert property (
    tick |=> (!tick)[*8])
    else $error("tick too frequent");
  chk_power_up: assert property (
    $fell(reset) |-> sleeping && regs_q.deb == `KMS_RST_DEB)
    else $error("bad power-up state");

  cov_repeat: cover property (rep_take);
  cov_high_key: cover property (pop && hi_key);
  cov_wake: cover property (waking ##1 running);
  cov_full: cover property (!fifo_rdy && (key_push || rep_push));
endmodule

// >>> kms_host.sv
`timescale 1ns/100ps
`include "kms_consts.svh"

module kms_host
(
  // clock
  input  wire logic       mclk,
  // register port towards the device
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  // released lines show the inverse, never the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge mclk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask

  // keys 62 and 63 carry no more flag, so one extra read decides
  task automatic drain(output logic [7:0] last, output int n);
    logic [7:0] d;
    logic       more;
    n    = 0;
    more = 1'b1;
    d    = 8'h00;
    while (more && n < 8)
    begin
      rd(`KMS_A_FIFO, d);
      n    = n + 1;
      more = d[7];
      if (!more && d[5:0] >= 6'h3e)
      begin
        rd(`KMS_A_FIFO, d);
        n    = n + 1;
        more = d[7];
      end
    end
    last = d;
  endtask
endmodule

// >>> test_key_matrix_scan_fifo.sv
`timescale 1ns/100ps
`include "kms_consts.svh"

module test_key_matrix_scan_fifo;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
  } kms_row_type;

  logic        mclk;
  logic        reset;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [63:0] scan_row;
  logic [5:0]  col_o;
  logic [5:0]  col_oe;
  logic        irq_o;
  logic        irq_oe;
  int          n_fail;
  int          total_checks;
  kms_row_type rows [17];
  logic [7:0]  d;
  logic [5:0]  mask;
  int          n;

  kms_host host
  (
    .mclk      (mclk),
    .reg_addr  (reg_addr),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata)
  );

  // short tick keeps debounce inside the run, still nine cycles apart
  kms_key_scanner #(.DEPTH(4), .TICK_CYC(9)) dut
  (
    .mclk                    (mclk),
    .reset                   (reset),
    .reg_addr                (reg_addr),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_wdata               (reg_wdata),
    .reg_rdata               (reg_rdata),
    .scan_row                (scan_row),
    .spare_column_outputs_o  (col_o),
    .spare_column_outputs_oe (col_oe),
    .key_event_irq_n_o       (irq_o),
    .key_event_irq_n_oe      (irq_oe)
  );

  always #2.5 mclk = ~mclk;

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic pins(input logic [5:0] exp_col, input logic exp_irq);
    repeat (3) @(posedge mclk);
    #1;
    check("column oe", {2'b00, col_oe}, {2'b00, exp_col});
    check("column level", {2'b00, col_o}, 8'h00);
    check("irq pin level", {7'h00, irq_o}, 8'h00);
    check("irq pin oe", {7'h00, irq_oe}, {7'h00, exp_irq});
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    test_done();
  end

  initial
  begin
    mclk         = 1'b0;
    reset        = 1'b1;
    scan_row     = 64'h0;
    n_fail       = 0;
    total_checks = 0;
    rows = '{
      '{1'b0, `KMS_A_FIFO,  8'h00, `KMS_EMPTY},
      '{1'b0, `KMS_A_CFG,   8'h00, `KMS_RST_CFG},
      '{1'b0, `KMS_A_DEB,   8'h00, `KMS_RST_DEB},
      '{1'b0, `KMS_A_IRQ,   8'h00, `KMS_RST_IRQ},
      '{1'b0, `KMS_A_PORTS, 8'h00, `KMS_RST_PORTS},
      '{1'b0, `KMS_A_REP,   8'h00, `KMS_RST_REP},
      '{1'b0, `KMS_A_SLEEP, 8'h00, `KMS_RST_SLEEP},
      '{1'b1, `KMS_A_DEB,   8'h3f, 8'h3f},
      '{1'b1, `KMS_A_IRQ,   8'he5, 8'he5},
      '{1'b1, `KMS_A_PORTS, 8'h03, 8'h03},
      '{1'b1, `KMS_A_REP,   8'hff, 8'hff},
      '{1'b1, `KMS_A_SLEEP, 8'h00, 8'h00},
      '{1'b1, `KMS_A_CFG,   8'h8a, 8'h8a},
      '{1'b1, `KMS_A_CFG,   8'h2a, 8'h2a},
      '{1'b1, 8'h07,        8'h55, 8'h00},
      '{1'b1, 8'hff,        8'haa, 8'h00},
      '{1'b1, `KMS_A_FIFO,  8'h12, `KMS_EMPTY}
    };
    repeat (4) @(posedge mclk);
    #1;
    reset = 1'b0;

    for (int i = 0; i < 17; i++)
    begin
      if (rows[i].wr)
        host.wr(rows[i].addr, rows[i].wdata);
      host.rd(rows[i].addr, d);
      check($sformatf("reg %h", rows[i].addr), d, rows[i].rdata);
    end
    $display("test register rows done");

    // all eight column codes with every level low
    host.wr(`KMS_A_PORTS, 8'h00);
    host.wr(`KMS_A_IRQ, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      host.wr(`KMS_A_DEB, {3'(k), 5'h00});
      mask = ~(6'h3f >> ((k > 6) ? 6 : k));
      pins(mask, 1'b1);
    end
    $display("test column codes done");

    host.wr(`KMS_A_PORTS, 8'ha8);
    pins(6'h15, 1'b1);
    host.wr(`KMS_A_PORTS, 8'h02);
    pins(6'h3f, 1'b0);
    host.wr(`KMS_A_PORTS, 8'h00);
    host.wr(`KMS_A_IRQ, 8'h01);
    pins(6'h3f, 1'b0);
    $display("test pin levels done");

    host.drain(d, n);
    check("empty drain reads", 8'(n), 8'h02);
    check("empty drain value", d, `KMS_EMPTY);
    $display("test empty drain done");

    // held key wakes the scanner; time interrupt after one debounce
    host.wr(`KMS_A_DEB, 8'h00);
    scan_row = 64'h0000_0000_0000_2000;
    repeat (17000) @(posedge mclk);
    pins(6'h00, 1'b1);
    host.rd(`KMS_A_CFG, d);
    check("awake run bit", d, 8'haa);
    host.rd(`KMS_A_FIFO, d);
    check("press col1 row5", d, 8'h0d);
    pins(6'h00, 1'b0);
    $display("test key wake done");

    // queue read clears the interrupt in this mode
    host.wr(`KMS_A_CFG, 8'h8a);
    scan_row = 64'h0;
    repeat (16000) @(posedge mclk);
    pins(6'h00, 1'b1);
    host.drain(d, n);
    check("release drain reads", 8'(n), 8'h01);
    check("release col1 row5", d, 8'h4d);
    pins(6'h00, 1'b0);
    $display("test key release done");

    // two keys at once, lowest first, count interrupt at two
    host.wr(`KMS_A_IRQ, 8'h20);
    scan_row = 64'h4000_0000_0000_0020;
    repeat (11000) @(posedge mclk);
    pins(6'h00, 1'b1);
    host.rd(`KMS_A_FIFO, d);
    check("key 5 more set", d, 8'h85);
    host.rd(`KMS_A_FIFO, d);
    check("key 62 no more", d, 8'h3e);
    host.rd(`KMS_A_FIFO, d);
    check("after key 62", d, `KMS_EMPTY);
    pins(6'h00, 1'b0);
    scan_row = 64'h0;
    $display("test two keys done");

    host.wr(`KMS_A_CFG, 8'h8a);
    host.wr(`KMS_A_REP, 8'h81);
    reset = 1'b1;
    pins(6'h00, 1'b0);
    check("rdata in reset", reg_rdata, 8'h00);
    reset = 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      host.rd(rows[i].addr, d);
      check($sformatf("reset reg %h", rows[i].addr), d, rows[i].rdata);
    end
    $display("test second reset done");
    test_done();
  end
endmodule
